// ---- verilog/fetsc_pkg.sv ----
/*
 * constants, carriers and state types of the fast ethernet transmit symbol coder.
 * assumes a single clock that runs at the symbol bit rate.
 */
package fetsc_pkg;

	// ***************************************
	// widths and counts
	// ***************************************
	localparam int          FETSC_NIB_W      = 4;
	localparam int          FETSC_CG_W       = 5;
	localparam int          FETSC_LFSR_W     = 11;
	localparam int          FETSC_FIFO_DEPTH = 16;
	localparam logic [2:0]  FETSC_BIT_LAST   = 3'h4;
	localparam logic [1:0]  FETSC_SETTLE     = 2'h3;
	localparam int          FETSC_TAP_HI     = 10;
	localparam int          FETSC_TAP_LO     = 8;
	localparam logic [6:0]  FETSC_SEED_LOW   = 7'h7f;

	// ***************************************
	// control code groups and nibbles
	// ***************************************
	localparam logic [4:0]  FETSC_CG_IDLE    = 5'h1f;
	localparam logic [4:0]  FETSC_CG_J       = 5'h18;
	localparam logic [4:0]  FETSC_CG_K       = 5'h11;
	localparam logic [4:0]  FETSC_CG_T       = 5'h0d;
	localparam logic [4:0]  FETSC_CG_R       = 5'h07;
	localparam logic [4:0]  FETSC_CG_HALT    = 5'h04;
	localparam logic [3:0]  FETSC_NIB_PRE    = 4'h5;
	localparam logic [3:0]  FETSC_NIB_ZERO   = 4'h0;

	// ***************************************
	// types
	// ***************************************
	typedef enum logic [2:0] {
		FETSC_TX_IDLE = 3'b000,
		FETSC_TX_J    = 3'b001,
		FETSC_TX_K    = 3'b011,
		FETSC_TX_DATA = 3'b010,
		FETSC_TX_T    = 3'b110,
		FETSC_TX_R    = 3'b111
	} fetsc_tx_state_e;

	typedef enum logic {
		FETSC_RX_HUNT = 1'b0,
		FETSC_RX_DATA = 1'b1
	} fetsc_rx_state_e;

	typedef enum logic [2:0] {
		FETSC_K_DATA, FETSC_K_IDLE, FETSC_K_START, FETSC_K_END,
		FETSC_K_HALT, FETSC_K_BAD
	} fetsc_kind_e;

	typedef struct packed {
		logic       tx_en;
		logic [3:0] nibble;
	} fetsc_tx_word_s;

	typedef struct packed {
		logic       valid;
		logic       dv;
		logic       er;
		logic [3:0] nibble;
	} fetsc_rx_nib_s;

	typedef struct packed {
		fetsc_kind_e kind;
		logic [3:0]  nibble;
	} fetsc_dec_s;

endpackage : fetsc_pkg

// ---- verilog/fetsc_fifo.sv ----
/*
 * small synchronous fifo with a registered head word.
 * assumes one clock and a synchronous, already synchronised reset.
 */
`timescale 1ns/1ns
module fetsc_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic [WIDTH-1:0]      out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             head_valid_reg;
	logic [WIDTH-1:0] head_reg;
	logic             push;
	logic             load;

	// head register is the read port; the array itself is never read combinationally out
	assign in_ready_out  = (count_reg != (AW+1)'(DEPTH)) && rst_n_in;
	assign push          = in_valid_in && in_ready_out;
	assign load          = (count_reg != '0) && (!head_valid_reg || out_ready_in);
	assign out_valid_out = head_valid_reg;
	assign out_data_out  = head_reg;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (load) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			head_valid_reg <= 1'b0;
			head_reg       <= '0;
		end else if (load) begin
			head_valid_reg <= 1'b1;
			head_reg       <= mem_reg[rd_ptr_reg];
		end else if (out_ready_in) begin
			head_valid_reg <= 1'b0;
		end
	end

endmodule : fetsc_fifo

// ---- verilog/fetsc_coder.sv ----
/*
 * transmit symbol coder of a 100 mb/s port: 4b5b encode, scramble, nrzi,
 * three-level split, fiber bypass, and the matching receive code decoder.
 * assumes clk_in is the symbol bit clock and the mac feeds nibble words
 * on the same clock through a valid/ready handshake.
 */
`timescale 1ns/1ns
module fetsc_coder #(
	parameter int FIFO_DEPTH = fetsc_pkg::FETSC_FIFO_DEPTH
) (
	input  wire logic                     clk_in,
	input  wire logic                     nrst_in,
	input  wire fetsc_pkg::fetsc_tx_word_s tx_word_in,
	input  wire logic                     tx_valid_in,
	output logic                          tx_ready_out,
	input  wire logic [4:0]               phy_address_strap_in,
	input  wire logic                     fiber_mode_in,
	output logic                          mlt_pos_out,
	output logic                          mlt_neg_out,
	output logic                          fx_nrzi_out,
	input  wire logic                     rx_bit_in,
	output fetsc_pkg::fetsc_rx_nib_s       rx_nib_out
);
	import fetsc_pkg::*;

	// ***************************************
	// code table functions
	// ***************************************
	function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
		logic [4:0] cg;
		cg = FETSC_CG_IDLE;
		case (nib)
			4'h0: cg = 5'h1e;
			4'h1: cg = 5'h09;
			4'h2: cg = 5'h14;
			4'h3: cg = 5'h15;
			4'h4: cg = 5'h0a;
			4'h5: cg = 5'h0b;
			4'h6: cg = 5'h0e;
			4'h7: cg = 5'h0f;
			4'h8: cg = 5'h12;
			4'h9: cg = 5'h13;
			4'ha: cg = 5'h16;
			4'hb: cg = 5'h17;
			4'hc: cg = 5'h1a;
			4'hd: cg = 5'h1b;
			4'he: cg = 5'h1c;
			default: cg = 5'h1d;
		endcase
		return cg;
	endfunction : encode_nibble

	function automatic fetsc_dec_s decode_group(input logic [4:0] cg);
		fetsc_dec_s d;
		d.kind   = FETSC_K_DATA;
		d.nibble = FETSC_NIB_ZERO;
		case (cg)
			5'h1e: d.nibble = 4'h0;
			5'h09: d.nibble = 4'h1;
			5'h14: d.nibble = 4'h2;
			5'h15: d.nibble = 4'h3;
			5'h0a: d.nibble = 4'h4;
			5'h0b: d.nibble = 4'h5;
			5'h0e: d.nibble = 4'h6;
			5'h0f: d.nibble = 4'h7;
			5'h12: d.nibble = 4'h8;
			5'h13: d.nibble = 4'h9;
			5'h16: d.nibble = 4'ha;
			5'h17: d.nibble = 4'hb;
			5'h1a: d.nibble = 4'hc;
			5'h1b: d.nibble = 4'hd;
			5'h1c: d.nibble = 4'he;
			5'h1d: d.nibble = 4'hf;
			FETSC_CG_IDLE: d.kind = FETSC_K_IDLE;
			FETSC_CG_J, FETSC_CG_K: begin
				d.kind   = FETSC_K_START;
				d.nibble = FETSC_NIB_PRE;
			end
			FETSC_CG_T, FETSC_CG_R: d.kind = FETSC_K_END;
			FETSC_CG_HALT: d.kind = FETSC_K_HALT;
			default: d.kind = FETSC_K_BAD;
		endcase
		return d;
	endfunction : decode_group

	// ***************************************
	// reset release and pin synchronisers
	// ***************************************
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic [4:0] strap_meta_reg;
	logic [4:0] strap_sync_reg;
	logic       fiber_meta_reg;
	logic       fiber_reg;
	logic       rx_meta_reg;
	logic       rx_sync_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	always_ff @(posedge clk_in) begin
		strap_meta_reg <= phy_address_strap_in;
		strap_sync_reg <= strap_meta_reg;
		fiber_meta_reg <= fiber_mode_in;
		fiber_reg      <= fiber_meta_reg;
		rx_meta_reg    <= rx_bit_in;
		rx_sync_reg    <= rx_meta_reg;
	end

	// ***************************************
	// transmit nibble buffer
	// ***************************************
	fetsc_tx_word_s head;
	logic           head_valid;
	logic           tx_pop;

	fetsc_fifo #(
		.WIDTH ($bits(fetsc_tx_word_s)),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n),
		.in_data_in    (tx_word_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.out_data_out  (head),
		.out_valid_out (head_valid),
		.out_ready_in  (tx_pop)
	);

	// ***************************************
	// transmit framing state machine
	// ***************************************
	fetsc_tx_state_e tx_state_reg;
	fetsc_tx_state_e tx_state_next;
	logic [2:0]      bit_cnt_reg;
	logic [4:0]      shift_reg;
	logic [4:0]      cg_next;
	logic            boundary;
	logic            head_en;
	logic            head_gap;

	assign boundary = (bit_cnt_reg == FETSC_BIT_LAST);
	assign head_en  = head_valid && head.tx_en;
	assign head_gap = head_valid && !head.tx_en;

	// groups are chosen only at the last bit of the current group, so the
	// fifo is drained at one nibble per five clocks and stalls the mac otherwise
	always_comb begin
		tx_state_next = tx_state_reg;
		cg_next       = FETSC_CG_IDLE;
		tx_pop        = 1'b0;
		case (tx_state_reg)
			FETSC_TX_J: begin
				cg_next       = FETSC_CG_K;
				tx_pop        = head_en;
				tx_state_next = FETSC_TX_K;
			end
			FETSC_TX_K, FETSC_TX_DATA: begin
				if (head_en) begin
					cg_next       = encode_nibble(head.nibble);
					tx_pop        = 1'b1;
					tx_state_next = FETSC_TX_DATA;
				end else if (head_gap) begin
					cg_next       = FETSC_CG_T;
					tx_pop        = 1'b1;
					tx_state_next = FETSC_TX_T;
				end else begin
					// mac underran mid frame: mark the hole instead of faking data
					cg_next       = FETSC_CG_HALT;
					tx_state_next = FETSC_TX_DATA;
				end
			end
			FETSC_TX_T: begin
				cg_next       = FETSC_CG_R;
				tx_state_next = FETSC_TX_R;
			end
			default: begin
				if (head_en) begin
					cg_next       = FETSC_CG_J;
					tx_pop        = 1'b1;
					tx_state_next = FETSC_TX_J;
				end else begin
					cg_next       = FETSC_CG_IDLE;
					tx_pop        = head_gap;
					tx_state_next = FETSC_TX_IDLE;
				end
			end
		endcase
		if (!boundary) begin
			tx_pop        = 1'b0;
			tx_state_next = tx_state_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			tx_state_reg <= FETSC_TX_IDLE;
		end else begin
			tx_state_reg <= tx_state_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			bit_cnt_reg <= 3'h0;
			shift_reg   <= FETSC_CG_IDLE;
		end else if (boundary) begin
			bit_cnt_reg <= 3'h0;
			shift_reg   <= cg_next;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg   <= {shift_reg[3:0], 1'b1};
		end
	end

	// ***************************************
	// scrambler
	// ***************************************
	logic [10:0] lfsr_reg;
	logic [1:0]  settle_reg;
	logic        code_bit;
	logic        scr_bit;
	logic        line_bit;

	// seed waits for the strap synchroniser to fill after reset release
	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			settle_reg <= 2'h0;
			lfsr_reg   <= {4'h0, FETSC_SEED_LOW};
		end else if (settle_reg != FETSC_SETTLE) begin
			settle_reg <= settle_reg + 2'h1;
			lfsr_reg   <= {strap_sync_reg[4:1], FETSC_SEED_LOW};
		end else begin
			lfsr_reg <= {lfsr_reg[9:0],
				lfsr_reg[FETSC_TAP_HI] ^ lfsr_reg[FETSC_TAP_LO]};
		end
	end

	assign code_bit = shift_reg[4];
	assign scr_bit  = code_bit ^ lfsr_reg[FETSC_TAP_HI];
	assign line_bit = fiber_reg ? code_bit : scr_bit;

	// ***************************************
	// nrzi and three-level split
	// ***************************************
	logic [1:0] mlt_phase_reg;
	logic       nrzi_reg;
	logic       pos_reg;
	logic       neg_reg;
	logic       fx_reg;
	logic [1:0] mlt_phase_next;
	logic       nrzi_next;

	assign nrzi_next      = nrzi_reg ^ line_bit;
	assign mlt_phase_next = (nrzi_next != nrzi_reg) ? mlt_phase_reg + 2'h1 : mlt_phase_reg;

	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			nrzi_reg      <= 1'b0;
			mlt_phase_reg <= 2'h0;
		end else begin
			nrzi_reg      <= nrzi_next;
			mlt_phase_reg <= mlt_phase_next;
		end
	end

	// each nrzi transition steps 0, +, 0, -, so ones alternate between streams
	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			pos_reg <= 1'b0;
			neg_reg <= 1'b0;
			fx_reg  <= 1'b0;
		end else begin
			pos_reg <= !fiber_reg && (mlt_phase_next == 2'h1);
			neg_reg <= !fiber_reg && (mlt_phase_next == 2'h3);
			fx_reg  <= fiber_reg && nrzi_next;
		end
	end

	assign mlt_pos_out = pos_reg;
	assign mlt_neg_out = neg_reg;
	assign fx_nrzi_out = fx_reg;

	// ***************************************
	// receive alignment and decode
	// ***************************************
	fetsc_rx_state_e rx_state_reg;
	logic [9:0]      rx_win_reg;
	logic            rx_prev_reg;
	logic [2:0]      rx_cnt_reg;
	logic            rx_pend_reg;
	logic            rx_idle_reg;
	fetsc_rx_nib_s   rx_reg;
	logic            rx_nrz;
	logic [4:0]      rx_group;
	fetsc_dec_s      rx_dec;

	// no descrambler here: the serial input is nrzi of unscrambled code
	assign rx_nrz   = rx_sync_reg ^ rx_prev_reg;
	assign rx_group = {rx_win_reg[3:0], rx_nrz};
	assign rx_dec   = decode_group(rx_group);

	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			rx_prev_reg <= rx_sync_reg;
			rx_win_reg  <= 10'h000;
		end else begin
			rx_prev_reg <= rx_sync_reg;
			rx_win_reg  <= {rx_win_reg[8:0], rx_nrz};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n) begin
			rx_state_reg <= FETSC_RX_HUNT;
			rx_cnt_reg   <= 3'h0;
			rx_pend_reg  <= 1'b0;
			rx_idle_reg  <= 1'b0;
			rx_reg       <= '0;
		end else begin
			rx_reg.valid <= 1'b0;
			rx_pend_reg  <= 1'b0;
			if (rx_pend_reg) begin
				rx_reg.valid  <= 1'b1;
				rx_reg.nibble <= FETSC_NIB_PRE;
			end
			if (rx_state_reg == FETSC_RX_HUNT) begin
				rx_reg.dv <= 1'b0;
				if ({rx_win_reg[8:0], rx_nrz} == {FETSC_CG_J, FETSC_CG_K}) begin
					rx_reg.er     <= 1'b0;
					rx_state_reg  <= FETSC_RX_DATA;
					rx_cnt_reg    <= 3'h0;
					rx_idle_reg   <= 1'b0;
					rx_pend_reg   <= 1'b1;
					rx_reg.valid  <= 1'b1;
					rx_reg.dv     <= 1'b1;
					rx_reg.nibble <= FETSC_NIB_PRE;
				end
			end else if (rx_cnt_reg != FETSC_BIT_LAST) begin
				rx_cnt_reg <= rx_cnt_reg + 3'h1;
			end else begin
				rx_cnt_reg    <= 3'h0;
				rx_reg.valid  <= 1'b1;
				rx_reg.dv     <= 1'b1;
				rx_reg.er     <= 1'b0;
				rx_reg.nibble <= rx_dec.nibble;
				rx_idle_reg   <= 1'b0;
				case (rx_dec.kind)
					FETSC_K_DATA: rx_reg.er <= 1'b0;
					FETSC_K_END: begin
						// second end group closes the frame
						if (rx_group == FETSC_CG_R) begin
							rx_state_reg <= FETSC_RX_HUNT;
						end
					end
					FETSC_K_IDLE: begin
						// idle in data is invalid; two in a row drop back to hunting
						rx_reg.er     <= 1'b1;
						rx_reg.nibble <= FETSC_NIB_ZERO;
						rx_idle_reg   <= 1'b1;
						if (rx_idle_reg) begin
							rx_state_reg <= FETSC_RX_HUNT;
						end
					end
					default: begin
						rx_reg.er     <= 1'b1;
						rx_reg.nibble <= FETSC_NIB_ZERO;
					end
				endcase
			end
		end
	end

	assign rx_nib_out = rx_reg;

endmodule : fetsc_coder

// ---- sim/fetsc_coder_monitor.sv ----
/*
 * port checker of the symbol coder: three-level streams, mode split, receive nibbles.
 * assumes it is bound onto fetsc_coder and that everything runs on clk_in.
 */
`timescale 1ns/1ns
module fetsc_coder_monitor
	import fetsc_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic           clk_in,
	input wire logic           nrst_in,
	input wire fetsc_tx_word_s tx_word_in,
	input wire logic           tx_valid_in,
	input wire logic           tx_ready_out,
	input wire logic [4:0]     phy_address_strap_in,
	input wire logic           fiber_mode_in,
	input wire logic           mlt_pos_out,
	input wire logic           mlt_neg_out,
	input wire logic           fx_nrzi_out,
	input wire logic           rx_bit_in,
	input wire fetsc_rx_nib_s  rx_nib_out
);
	// ***************************************
	// helpers
	// ***************************************
	logic       last_neg_reg;
	logic [2:0] fib_cnt_reg;
	logic [2:0] cop_cnt_reg;

	// phase starts at zero, so the first pole after reset is positive
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			last_neg_reg <= 1'b1;
		else if (mlt_pos_out)
			last_neg_reg <= 1'b0;
		else if (mlt_neg_out)
			last_neg_reg <= 1'b1;
	end

	// mode pin passes two sync flops and the line register, so wait seven cycles
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			fib_cnt_reg <= 3'h0;
		else if (!fiber_mode_in)
			fib_cnt_reg <= 3'h0;
		else if (fib_cnt_reg != 3'h7)
			fib_cnt_reg <= fib_cnt_reg + 3'h1;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			cop_cnt_reg <= 3'h0;
		else if (fiber_mode_in)
			cop_cnt_reg <= 3'h0;
		else if (cop_cnt_reg != 3'h7)
			cop_cnt_reg <= cop_cnt_reg + 3'h1;
	end

	// ***************************************
	// properties
	// ***************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_mlt_one_pole: assert property (!(mlt_pos_out && mlt_neg_out))
		else $error("both line streams high");
	a_pole_via_zero: assert property ((mlt_pos_out |=> !mlt_neg_out) and
		(mlt_neg_out |=> !mlt_pos_out))
		else $error("line jumped between poles");
	a_pole_alternate: assert property (($rose(mlt_pos_out) |-> last_neg_reg) and
		($rose(mlt_neg_out) |-> !last_neg_reg))
		else $error("same pole twice in a row");
	a_fiber_no_mlt: assert property (fib_cnt_reg == 3'h7 |-> !mlt_pos_out && !mlt_neg_out)
		else $error("three-level stream active in fiber mode");
	a_copper_no_fx: assert property (cop_cnt_reg == 3'h7 |-> !fx_nrzi_out)
		else $error("binary line output active in copper mode");
	a_preamble_pair: assert property (rx_nib_out.valid && $past(rx_nib_out.valid) |->
		rx_nib_out.nibble == FETSC_NIB_PRE && $past(rx_nib_out.nibble) == FETSC_NIB_PRE &&
		rx_nib_out.dv ##1 !rx_nib_out.valid [*3] ##1 rx_nib_out.valid)
		else $error("start pair not returned as two preamble nibbles");
	a_bad_gives_zero: assert property (rx_nib_out.valid && rx_nib_out.er |->
		rx_nib_out.nibble == FETSC_NIB_ZERO)
		else $error("error nibble not zero");
	a_rx_held: assert property (!rx_nib_out.valid |-> $stable(rx_nib_out.nibble) &&
		$stable(rx_nib_out.er) && !$rose(rx_nib_out.dv))
		else $error("receive nibble changed between pulses");

	c_rx_error: cover property (rx_nib_out.valid && rx_nib_out.er);
	c_neg_pole: cover property ($rose(mlt_neg_out));
	c_refused: cover property (tx_valid_in && !tx_ready_out);
	c_fiber_line: cover property (fib_cnt_reg == 3'h7 && fx_nrzi_out);
endmodule : fetsc_coder_monitor

bind fetsc_coder fetsc_coder_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_monitor (.clk_in, .nrst_in,
	.tx_word_in, .tx_valid_in, .tx_ready_out, .phy_address_strap_in, .fiber_mode_in,
	.mlt_pos_out, .mlt_neg_out, .fx_nrzi_out, .rx_bit_in, .rx_nib_out);

// ---- sim/fetsc_mac_model.sv ----
/*
 * mac side model: offers queued nibble words with valid, holds each until taken.
 * assumes the bench fills the queue through push and reads pending.
 */
`timescale 1ns/1ns
module fetsc_mac_model
	import fetsc_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     tx_ready_in,
	output fetsc_tx_word_s tx_word_out,
	output logic          tx_valid_out
);
	// ***************************************
	// word queue
	// ***************************************
	fetsc_tx_word_s q [$];
	logic           taken;

	task automatic push(input fetsc_tx_word_s w);
		q.push_back(w);
	endtask : push

	function automatic int pending();
		return q.size();
	endfunction : pending

	initial begin
		tx_word_out = '0;
		tx_valid_out = 1'b0;
	end

	// a released word bus shows the inverse so a stale value cannot pass for data
	always begin
		@(posedge clk_in);
		taken = tx_valid_out && tx_ready_in;
		#1;
		if (taken)
			q.delete(0);
		if (q.size() > 0) begin
			tx_word_out = q[0];
			tx_valid_out = 1'b1;
		end else begin
			if (tx_valid_out)
				tx_word_out = ~tx_word_out;
			tx_valid_out = 1'b0;
		end
	end
endmodule : fetsc_mac_model

// ---- sim/test_fast_ethernet_tx_symbol_coder.sv ----
/*
 * self-checking bench of the symbol coder in copper and fiber mode.
 * assumes fetsc_coder, its checker and the mac model are compiled before it.
 */
`timescale 1ns/1ns
module test_fast_ethernet_tx_symbol_coder;
	import fetsc_pkg::*;
	// ***************************************
	// signals
	// ***************************************
	localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
		5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	localparam logic [4:0] BAD [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08,
		5'h0c, 5'h04, 5'h18, 5'h11, 5'h1f};
	logic           clk_in = 1'b0;
	logic           nrst_in = 1'b0;
	fetsc_tx_word_s tx_word_in;
	logic           tx_valid_in;
	logic           tx_ready_out;
	logic [4:0]     phy_address_strap_in = 5'h00;
	logic           fiber_mode_in = 1'b0;
	logic           mlt_pos_out;
	logic           mlt_neg_out;
	logic           fx_nrzi_out;
	logic           rx_bit_in = 1'b0;
	fetsc_rx_nib_s  rx_nib_out;
	logic [31:0]    seed = 32'hee3ee9a9;
	logic [4:0]     exp_cg [$];
	logic [4:0]     exp_rx [$];
	logic [10:0]    hist = '0;
	logic [9:0]     sr = '0;
	logic [1:0]     lvl_prev = '0;
	logic           b;
	logic           k;
	logic           c;
	logic [4:0]     e;
	int             nknown = 0;
	int             bitcnt = 0;
	int             n_halt = 0;
	bit             in_frame = 0;
	bit             halt_ok = 0;
	int             n_errors = 0;
	int             checked = 0;

	always #10 clk_in = ~clk_in;

	fetsc_coder #(.FIFO_DEPTH(16)) uut (.clk_in, .nrst_in, .tx_word_in, .tx_valid_in,
		.tx_ready_out, .phy_address_strap_in, .fiber_mode_in, .mlt_pos_out, .mlt_neg_out,
		.fx_nrzi_out, .rx_bit_in, .rx_nib_out);
	fetsc_mac_model mac (.clk_in, .tx_ready_in(tx_ready_out), .tx_word_out(tx_word_in),
		.tx_valid_out(tx_valid_in));

	// ***************************************
	// helpers
	// ***************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk_line(input string what, input logic [4:0] ev, input logic [4:0] gv);
		checked++;
		if (gv !== ev) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, ev, gv);
		end
	endtask : chk_line

	task automatic chk_nib(input logic [4:0] ev, input logic [4:0] gv);
		checked++;
		if (gv !== ev) begin
			n_errors++;
			$display("Error rx_nibble expected %h seen %h", ev, gv);
		end
	endtask : chk_nib

	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// ***************************************
	// line decoder: undo nrzi, self-sync descramble on idle, frame on the start pair
	// ***************************************
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			nknown = 0;
			in_frame = 0;
			lvl_prev = '0;
		end else begin
			b = fiber_mode_in ? fx_nrzi_out ^ lvl_prev[0] : {mlt_pos_out, mlt_neg_out} != lvl_prev;
			lvl_prev = fiber_mode_in ? {1'b0, fx_nrzi_out} : {mlt_pos_out, mlt_neg_out};
			k = (nknown < 30) ? ~b : hist[10] ^ hist[8];
			hist = {hist[9:0], k};
			c = fiber_mode_in ? b : b ^ k;
			sr = {sr[8:0], c};
			nknown = (nknown < 30) ? nknown + 1 : nknown;
			if (!in_frame) begin
				if (sr == {FETSC_CG_J, FETSC_CG_K}) begin
					in_frame = 1;
					bitcnt = 0;
					chk_line("start_j", exp_cg.size() ? exp_cg.pop_front() : 5'h1f, sr[9:5]);
					chk_line("start_k", exp_cg.size() ? exp_cg.pop_front() : 5'h1f, sr[4:0]);
				end else if (nknown == 30 && exp_cg.size() == 0)
					chk_line("idle_bit", 5'h01, {4'h0, c});
			end else if (++bitcnt == 5) begin
				bitcnt = 0;
				if (halt_ok && sr[4:0] == FETSC_CG_HALT)
					n_halt++;
				else begin
					e = exp_cg.size() ? exp_cg.pop_front() : 5'h1f;
					chk_line("code_group", e, sr[4:0]);
					in_frame = (e != FETSC_CG_R);
				end
			end
		end
	end

	always @(posedge clk_in)
		if (nrst_in && rx_nib_out.valid)
			chk_nib(exp_rx.size() ? exp_rx.pop_front() : 5'h1f, {rx_nib_out.er, rx_nib_out.nibble});

	// ***************************************
	// stimulus
	// ***************************************
	task automatic wait_tx();
		for (int t = 0; t < 3000 && (exp_cg.size() > 0 || mac.pending() > 0); t++)
			@(posedge clk_in);
		#1;
	endtask : wait_tx

	// words go in back to back, so a long frame fills the fifo until ready drops
	task automatic tx_frame(input int n, input bit stall);
		fetsc_tx_word_s w;
		wait_tx();
		repeat (rnd() % 20) @(posedge clk_in);
		#1;
		halt_ok = stall;
		for (int i = 0; i < n + 2; i++) begin
			w.tx_en = 1'b1;
			w.nibble = (i < 2) ? FETSC_NIB_PRE : 4'(rnd());
			exp_cg.push_back(i == 0 ? FETSC_CG_J : i == 1 ? FETSC_CG_K : ENC[w.nibble]);
			mac.push(w);
			if (stall && i == n / 2 + 2) begin
				for (int t = 0; t < 200 && mac.pending() > 0; t++)
					@(posedge clk_in);
				repeat (60) @(posedge clk_in);
				#1;
			end
		end
		exp_cg.push_back(FETSC_CG_T);
		exp_cg.push_back(FETSC_CG_R);
		w.tx_en = 1'b0;
		mac.push(w);
		mac.push(w);
	endtask : tx_frame

	task automatic rx_group(input logic [4:0] g, input logic [4:0] ev, input bit expect_it);
		if (expect_it)
			exp_rx.push_back(ev);
		for (int i = 4; i >= 0; i--) begin
			@(posedge clk_in);
			#1;
			rx_bit_in = rx_bit_in ^ g[i];
		end
	endtask : rx_group

	task automatic rx_frame(input int n, input bit bad);
		logic [3:0] d;
		repeat (3) rx_group(FETSC_CG_IDLE, 5'h00, 0);
		rx_group(FETSC_CG_J, {1'b0, FETSC_NIB_PRE}, 1);
		rx_group(FETSC_CG_K, {1'b0, FETSC_NIB_PRE}, 1);
		for (int i = 0; i < n; i++) begin
			d = 4'(rnd());
			rx_group(ENC[d], {1'b0, d}, 1);
			if (bad && i < 12)
				rx_group(BAD[i], 5'h10, 1);
		end
		// a bad frame ends on a second idle in a row; the end pair then falls in hunting
		if (bad)
			rx_group(FETSC_CG_IDLE, 5'h10, 1);
		rx_group(FETSC_CG_T, 5'h00, !bad);
		rx_group(FETSC_CG_R, 5'h00, !bad);
	endtask : rx_frame

	task automatic run(input bit fiber);
		@(posedge clk_in);
		#1;
		nrst_in = 1'b0;
		fiber_mode_in = fiber;
		phy_address_strap_in = 5'(rnd());
		repeat (20) @(posedge clk_in);
		#1;
		nrst_in = 1'b1;
		repeat (60) @(posedge clk_in);
		fork
			begin
				tx_frame(1, 0);
				tx_frame(40, 0);
				tx_frame(12, 1);
				repeat (3) tx_frame(2 + int'(rnd() % 20), 0);
				wait_tx();
			end
			begin
				rx_frame(0, 0);
				rx_frame(12, 1);
				repeat (3) rx_frame(1 + int'(rnd() % 10), 0);
				repeat (4) rx_group(FETSC_CG_IDLE, 5'h00, 0);
			end
		join
		repeat (100) @(posedge clk_in);
		chk_line("tx_left", 5'h00, 5'(exp_cg.size()));
		chk_line("rx_left", 5'h00, 5'(exp_rx.size()));
		chk_line("halt_seen", 5'h01, {4'h0, n_halt > 0});
		n_halt = 0;
	endtask : run

	initial begin
		run(1'b0);
		run(1'b1);
		test_done();
	end

	initial begin
		repeat (40000) @(posedge clk_in);
		n_errors++;
		test_done();
	end
endmodule : test_fast_ethernet_tx_symbol_coder
